/* src/hdsp_top.sv */
// hdsp_top: half-duplex serial port with wishbone registers
// assumes classic wishbone master, one clock, pins from outside
//
// Contract
// - line character is start, nine data bits, stop: eleven bits.
// - half duplex; starting a transmit aborts any reception.
// - received character goes to a buffer, freeing the shifter.
// - transmitter output is inverted before the pin.
// - pin follows port register while output select is inactive.
// - receive pin is always readable as plain input.
// - timing comes from the always-running system clock.
// - divider makes the serial state clock from a selected divisor.
// - eight states per bit.
// - three samples per bit, two-of-three majority.
// - start and stop inserted by hardware.
// - character options all fit the nine-bit frame.
// - ninth bit kept until software or a reception changes it.
// - writing data starts a transmission.
// - start low, eight data lsb first, then ninth bit.
// - one stop bit high, then output select releases pin.
// - end of transmit sets tx empty flag, interrupt if enabled.
// - tx empty clears by writing zero or by a data write.
// - writing one to tx empty sets it, software interrupt.
// - receiver waits for falling edge, then one start bit time.
// - after nine bits and stop, buffer and set rx ready.
// - baud codes 0..6 pick divisors; 7 reserved; immediate effect.
`timescale 1ns/1ps
module hdsp_top
	import hdsp_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        SERIAL_IN_PIN,
	output logic             SERIAL_OUT_PIN,
	output logic             TX_IRQ,
	output logic             RX_IRQ
);
	import hdsp_pkg::*;

	logic        rx_s;
	logic        tick;
	logic [7:0]  tx_data_reg;
	logic [7:0]  rx_buf_reg;
	logic        ninth_bit_reg;
	logic [2:0]  baud_select_reg;
	logic        rxie_reg;
	logic        txie_reg;
	logic        tx_empty_flag_reg;
	logic        rx_ready_flag_reg;
	logic        port_reg;
	logic        tx_output_select_reg;
	hdsp_state_t tx_state_reg;
	hdsp_state_t rx_state_reg;
	logic [2:0]  tx_phase_reg;
	logic [3:0]  tx_bit_reg;
	logic [8:0]  tx_shift_reg;
	logic        tx_line_reg;
	logic [2:0]  rx_phase_reg;
	logic [3:0]  rx_bit_reg;
	logic [8:0]  rx_shift_reg;
	logic [1:0]  vote_reg;
	logic        rx_prev_reg;
	logic        wr;
	logic        rd;
	logic        data_wr;
	logic        ctrl_wr;
	logic        tx_done;
	logic        rx_done;
	logic        majority;
	logic [7:0]  ctrl_val;

	hdsp_sync u_sync (
		.clk   (SYS_CLK),
		.rst_n (RESET_N),
		.d     (SERIAL_IN_PIN),
		.q     (rx_s)
	);

	hdsp_baud_gen u_baud (
		.clk   (SYS_CLK),
		.rst_n (RESET_N),
		.sel   (baud_select_reg),
		.tick  (tick)
	);

	assign wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0];
	assign rd = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I;
	assign data_wr = wr && WB_ADR_I == ADDR_DATA;
	assign ctrl_wr = wr && WB_ADR_I == ADDR_CTRL;
	assign tx_done = tick && tx_state_reg == ST_STOP && tx_phase_reg == 3'h7;
	assign rx_done = tick && rx_state_reg == ST_STOP && rx_phase_reg == 3'h7;
	assign ctrl_val = {rx_ready_flag_reg, tx_empty_flag_reg, rxie_reg, txie_reg,
		baud_select_reg, ninth_bit_reg};

	// wishbone ack and read data
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
			WB_DAT_O <= 32'h00000000;
			if (rd) begin
				case (WB_ADR_I)
					ADDR_DATA: WB_DAT_O <= {24'h000000, rx_buf_reg};
					ADDR_CTRL: WB_DAT_O <= {24'h000000, ctrl_val};
					ADDR_PORT: WB_DAT_O <= {31'h00000000, port_reg};
					ADDR_PINS: WB_DAT_O <= {31'h00000000, rx_s};
					default:   WB_DAT_O <= 32'h00000000;
				endcase
			end
		end
	end

	// control fields and port register
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			{rxie_reg, txie_reg, baud_select_reg} <= CTRL_RESET[5:1];
			port_reg <= PORT_RESET;
		end else begin
			if (ctrl_wr) begin
				rxie_reg        <= WB_DAT_I[CTRL_RXIE];
				txie_reg        <= WB_DAT_I[CTRL_TXIE];
				baud_select_reg <= WB_DAT_I[CTRL_BAUD_LO +: 3];
			end
			if (wr && WB_ADR_I == ADDR_PORT)
				port_reg <= WB_DAT_I[0];
		end
	end

	// ninth bit: software write or reception
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			ninth_bit_reg <= CTRL_RESET[CTRL_NINTH];
		end else if (rx_done) begin
			ninth_bit_reg <= rx_shift_reg[8];
		end else if (ctrl_wr) begin
			ninth_bit_reg <= WB_DAT_I[CTRL_NINTH];
		end
	end

	// tx empty flag; hardware set wins
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			tx_empty_flag_reg <= 1'b0;
		end else if (tx_done) begin
			tx_empty_flag_reg <= 1'b1;
		end else if (data_wr) begin
			tx_empty_flag_reg <= 1'b0;
		end else if (ctrl_wr) begin
			tx_empty_flag_reg <= WB_DAT_I[CTRL_TX_EMPTY_FLAG];
		end
	end

	// rx ready flag; hardware set wins
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			rx_ready_flag_reg <= 1'b0;
		end else if (rx_done) begin
			rx_ready_flag_reg <= 1'b1;
		end else if (ctrl_wr) begin
			rx_ready_flag_reg <= WB_DAT_I[CTRL_RX_READY_FLAG];
		end
	end

	// interrupt requests
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			TX_IRQ <= 1'b0;
			RX_IRQ <= 1'b0;
		end else begin
			TX_IRQ <= tx_empty_flag_reg && txie_reg;
			RX_IRQ <= rx_ready_flag_reg && rxie_reg;
		end
	end

	// transmitter
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			tx_state_reg         <= ST_IDLE;
			tx_phase_reg         <= 3'h0;
			tx_bit_reg           <= 4'h0;
			tx_shift_reg         <= 9'h1FF;
			tx_line_reg          <= 1'b1;
			tx_output_select_reg <= 1'b0;
			tx_data_reg          <= 8'h00;
		end else if (data_wr) begin
			tx_data_reg          <= WB_DAT_I[7:0];
			tx_shift_reg         <= {ninth_bit_reg, WB_DAT_I[7:0]};
			tx_state_reg         <= ST_START;
			tx_phase_reg         <= 3'h0;
			tx_bit_reg           <= 4'h0;
			tx_line_reg          <= 1'b0;
			tx_output_select_reg <= 1'b1;
		end else if (tick) begin
			tx_phase_reg <= tx_phase_reg + 3'h1;
			if (tx_phase_reg == 3'h7) begin
				case (tx_state_reg)
					ST_START: begin
						tx_state_reg <= ST_DATA;
						tx_line_reg  <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_bit_reg   <= 4'h1;
					end
					ST_DATA: begin
						if (tx_bit_reg == 4'(FRAME_DATA_BITS)) begin
							tx_state_reg <= ST_STOP;
							tx_line_reg  <= 1'b1;
						end else begin
							tx_line_reg  <= tx_shift_reg[0];
							tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
							tx_bit_reg   <= tx_bit_reg + 4'h1;
						end
					end
					ST_STOP: begin
						tx_state_reg         <= ST_IDLE;
						tx_output_select_reg <= 1'b0;
					end
					default: tx_state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// output pin mux with inversion of serial data
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N)
			SERIAL_OUT_PIN <= PORT_RESET;
		else if (tx_output_select_reg)
			SERIAL_OUT_PIN <= !tx_line_reg;
		else
			SERIAL_OUT_PIN <= port_reg;
	end

	// two early samples agree, or one of them plus the late sample
	assign majority = vote_reg[1] || (vote_reg[0] && rx_s);

	// receiver
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			rx_state_reg <= ST_IDLE;
			rx_phase_reg <= 3'h0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 9'h000;
			rx_buf_reg   <= 8'h00;
			vote_reg     <= 2'h0;
			rx_prev_reg  <= 1'b1;
		end else begin
			rx_prev_reg <= rx_s;
			if (data_wr || tx_output_select_reg) begin
				rx_state_reg <= ST_IDLE;
			end else if (rx_state_reg == ST_IDLE) begin
				if (rx_prev_reg && !rx_s) begin
					rx_state_reg <= ST_START;
					rx_phase_reg <= 3'h0;
					rx_bit_reg   <= 4'h0;
				end
			end else if (tick) begin
				rx_phase_reg <= rx_phase_reg + 3'h1;
				if (rx_phase_reg == 3'h0)
					vote_reg <= 2'h0;
				else if ((rx_phase_reg == SAMPLE_A || rx_phase_reg == SAMPLE_B) && rx_s)
					vote_reg <= vote_reg + 2'h1;
				if (rx_phase_reg == SAMPLE_C && rx_state_reg == ST_DATA)
					rx_shift_reg <= {majority, rx_shift_reg[8:1]};
				if (rx_phase_reg == 3'h7) begin
					case (rx_state_reg)
						ST_START: rx_state_reg <= ST_DATA;
						ST_DATA: begin
							rx_bit_reg <= rx_bit_reg + 4'h1;
							if (rx_bit_reg == 4'(FRAME_DATA_BITS - 1))
								rx_state_reg <= ST_STOP;
						end
						ST_STOP: begin
							rx_buf_reg   <= rx_shift_reg[7:0];
							rx_state_reg <= ST_IDLE;
						end
						default: rx_state_reg <= ST_IDLE;
					endcase
				end
			end
		end
	end
endmodule

/* src/hdsp_pkg.sv */
// hdsp_pkg: constants for the half-duplex serial port
// assumes a 250 MHz system clock driving every register
package hdsp_pkg;
	// register word byte addresses
	localparam logic [3:0] ADDR_DATA  = 4'h0;
	localparam logic [3:0] ADDR_CTRL  = 4'h4;
	localparam logic [3:0] ADDR_PORT  = 4'h8;
	localparam logic [3:0] ADDR_PINS  = 4'hC;
	// control register field positions
	localparam int CTRL_NINTH = 0;
	localparam int CTRL_BAUD_LO = 1;
	localparam int CTRL_TXIE = 4;
	localparam int CTRL_RXIE = 5;
	localparam int CTRL_TX_EMPTY_FLAG = 6;
	localparam int CTRL_RX_READY_FLAG = 7;
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic       PORT_RESET = 1'b1;
	// frame figures
	localparam int FRAME_DATA_BITS = 9;
	localparam int STATES_PER_BIT = 8;
	localparam logic [2:0] SAMPLE_A = 3'h3;
	localparam logic [2:0] SAMPLE_B = 3'h4;
	localparam logic [2:0] SAMPLE_C = 3'h5;
	localparam logic [2:0] BAUD_RESERVED = 3'h7;
	localparam int DIV_W = 13;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b011,
		ST_STOP  = 3'b010
	} hdsp_state_t;
	// baud divisor for an 8x state tick
	function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
		case (sel)
			3'h0:    baud_div = 13'h1A00;
			3'h1:    baud_div = 13'h0D00;
			3'h2:    baud_div = 13'h0680;
			3'h3:    baud_div = 13'h0340;
			3'h4:    baud_div = 13'h01A0;
			3'h5:    baud_div = 13'h0100;
			3'h6:    baud_div = 13'h00D0;
			default: baud_div = 13'h0000;
		endcase
	endfunction
endpackage

/* src/hdsp_baud_gen.sv */
// hdsp_baud_gen: divides the system clock into an 8x baud tick
// assumes the baud select code reaches it straight from the control register
`timescale 1ns/1ps
module hdsp_baud_gen
	import hdsp_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [2:0]       sel,
	output logic                  tick
);
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] div;
	assign div = baud_div(sel) / 13'h0008;
	// new selection acts at once
	always_ff @(posedge clk) begin
		if (!rst_n || sel == BAUD_RESERVED) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else if (cnt_reg >= div - 13'h0001) begin
			cnt_reg <= '0;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 13'h0001;
			tick    <= 1'b0;
		end
	end
endmodule

/* src/hdsp_sync.sv */
// hdsp_sync: two-flop synchroniser for the receive pin
// assumes an asynchronous pin level at the input
`timescale 1ns/1ps
module hdsp_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			q        <= 1'b1;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* sim/hdsp_props.sv */
// hdsp_props: assertions on the hdsp_top ports
// assumes a bind into hdsp_top, one clock domain
`timescale 1ns/1ps
module hdsp_props
	import hdsp_pkg::*;
(
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [3:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        SERIAL_IN_PIN,
	input wire logic        SERIAL_OUT_PIN,
	input wire logic        TX_IRQ,
	input wire logic        RX_IRQ
);
	logic        req;
	logic        wr;
	logic        wc;
	logic        port_reg;
	logic [2:0]  baud_reg;
	logic [16:0] busy_reg;
	logic [3:0]  hist_reg;
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr = req && WB_WE_I && WB_SEL_I[0];
	assign wc = wr && WB_ADR_I == ADDR_CTRL;
	// port value, baud code, frame length
	always_ff @(posedge SYS_CLK) begin
		hist_reg <= {hist_reg[2:0], SERIAL_IN_PIN};
		if (!RESET_N) begin
			port_reg <= 1'b1;
			baud_reg <= 3'h0;
			busy_reg <= 17'h0;
			hist_reg <= {4{~SERIAL_IN_PIN}};
		end else begin
			if (wr && WB_ADR_I == ADDR_PORT)
				port_reg <= WB_DAT_I[0];
			if (wc)
				baud_reg <= WB_DAT_I[3:1];
			if (wr && WB_ADR_I == ADDR_DATA)
				busy_reg <= baud_reg == 3'h6 ? 17'h0960 : baud_reg == 3'h5 ? 17'h0C00 :
					baud_reg == 3'h4 ? 17'h1300 : 17'h1FFFF;
			else if (busy_reg != 17'h0)
				busy_reg <= busy_reg - 17'h1;
		end
	end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	sequence s_pulse;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	sequence s_in_reset;
		!RESET_N [*2];
	endsequence
	AST_RESET_IDLE: assert property (disable iff (1'b0) s_in_reset |->
		SERIAL_OUT_PIN && !WB_ACK_O && !TX_IRQ && !RX_IRQ) else $error("not idle in reset");
	AST_ACK_PULSE: assert property (req |=> s_pulse)
		else $error("ack not one pulse");
	AST_DATA_CLR: assert property (wr && WB_ADR_I == ADDR_DATA |-> ##[1:3] !TX_IRQ)
		else $error("data write kept tx irq");
	AST_SW_SET: assert property (wc && WB_DAT_I[6] && WB_DAT_I[4] |-> ##[1:3] TX_IRQ)
		else $error("software set lost");
	AST_SW_CLR: assert property (wc && !(WB_DAT_I[6] && WB_DAT_I[4]) |-> ##[1:3] !TX_IRQ)
		else $error("tx irq not cleared");
	AST_RX_CLR: assert property (wc && !(WB_DAT_I[7] && WB_DAT_I[5]) |-> ##[1:3] !RX_IRQ)
		else $error("rx irq not cleared");
	AST_IDLE_PIN: assert property (busy_reg == 17'h0 && $stable(port_reg) |->
		SERIAL_OUT_PIN == port_reg) else $error("pin not port value");
	AST_PIN_READ: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == ADDR_PINS &&
		hist_reg == {4{SERIAL_IN_PIN}} |-> WB_DAT_O[0] == SERIAL_IN_PIN) else $error("pin read");
endmodule
bind hdsp_top hdsp_props hdsp_props_i (.SYS_CLK, .RESET_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .SERIAL_IN_PIN, .SERIAL_OUT_PIN,
	.TX_IRQ, .RX_IRQ);

/* sim/hdsp_remote.sv */
// hdsp_remote: remote station on the serial line
// assumes bit times in ns and the port register kept high
`timescale 1ns/1ps
module hdsp_remote (
	input  wire logic out_pin,
	output logic      line
);
	initial line = 1'b1;
	// one frame, optional short spike mid-bit
	task automatic send(input logic [8:0] d, input int bt, input logic spike);
		logic [10:0] f;
		f = {1'b1, d, 1'b0};
		for (int k = 0; k < 11; k++) begin
			line = f[k];
			#(bt / 2);
			line = f[k] ^ spike;
			#40;
			line = f[k];
			#(bt / 2 - 40);
		end
	endtask
	// samples the inverted pin mid-bit
	task automatic recv(input int bt, output logic [9:0] r);
		logic [11:0] s;
		#(bt / 2 + 60);
		for (int k = 0; k < 12; k++) begin
			s[k] = ~out_pin;
			#(bt);
		end
		r = {s[0] === 1'b0 && s[10] === 1'b1 && s[11] === 1'b0, s[9:1]};
	endtask
endmodule

/* sim/tb_hdsp_top.sv */
// tb_hdsp_top: self-checking bench for the serial port
// assumes hdsp_top, hdsp_remote and the bound checker
`timescale 1ns/1ps
module tb_hdsp_top;
	import hdsp_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [3:0]  sel = 4'hF;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic        ack;
	logic        line;
	logic        pin;
	logic        tx_irq;
	logic        rx_irq;
	int          bad_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	hdsp_top hdsp_top_i (.SYS_CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
		.WB_ACK_O(ack), .SERIAL_IN_PIN(line), .SERIAL_OUT_PIN(pin), .TX_IRQ(tx_irq),
		.RX_IRQ(rx_irq));
	hdsp_remote hdsp_remote_i (.out_pin(pin), .line(line));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = dat_r;
		cyc <= 1'b0;
		check(32'(n < 40), 32'h1);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		check(q, e);
	endtask
	task automatic wait_irq(input logic tx, input logic [31:0] e);
		int n;
		n = 0;
		while ((tx ? tx_irq : rx_irq) !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		check(32'(n < 4000), e);
	endtask
	task automatic t_reset();
		check(32'(pin), 32'h1);
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_PORT, 32'h1);
		rd(4'h2, 32'h0);
	endtask
	task automatic t_port();
		wr(ADDR_PORT, 8'h00);
		repeat (3) @(posedge clk);
		check(32'(pin), 32'h0);
		sel <= 4'h0;
		wr(ADDR_PORT, 8'h01);
		sel <= 4'hF;
		rd(ADDR_PORT, 32'h0);
		wr(ADDR_PORT, 8'h01);
		rd(ADDR_PINS, 32'h1);
	endtask
	task automatic t_tx();
		logic [9:0] r;
		int div [3] = '{32'h1A0, 32'h100, 32'h0D0};
		for (int i = 0; i < 4; i++) begin
			if (i < 3)
				wr(ADDR_CTRL, {4'h1, 3'(i + 4), 1'b1});
			wr(ADDR_DATA, 8'hA5 ^ 8'(i));
			repeat (2) @(posedge clk);
			check(32'(tx_irq), 32'h0);
			hdsp_remote_i.recv(div[(i < 3) ? i : 2] * 4, r);
			check({22'h0, r}, {22'h0, 2'h3, 8'hA5 ^ 8'(i)});
			check(32'(tx_irq), 32'h1);
		end
		wr(ADDR_CTRL, 8'h1D);
		repeat (2) @(posedge clk);
		check(32'(tx_irq), 32'h0);
		wr(ADDR_CTRL, 8'h5D);
		repeat (2) @(posedge clk);
		check(32'(tx_irq), 32'h1);
		rd(ADDR_CTRL, 32'h5D);
	endtask
	task automatic t_rx();
		wr(ADDR_CTRL, 8'h2C);
		fork
			hdsp_remote_i.send(9'h15A, 832, 1'b0);
			begin
				repeat (80) @(posedge clk);
				rd(ADDR_PINS, 32'h0);
			end
		join
		wait_irq(1'b0, 32'h1);
		fork
			hdsp_remote_i.send(9'h0C3, 832, 1'b1);
			begin
				repeat (400) @(posedge clk);
				rd(ADDR_CTRL, 32'hAD);
				rd(ADDR_DATA, 32'h5A);
				wr(ADDR_CTRL, 8'h2C);
			end
		join
		wait_irq(1'b0, 32'h1);
		rd(ADDR_CTRL, 32'hAC);
		rd(ADDR_DATA, 32'hC3);
	endtask
	task automatic t_abort();
		logic [9:0] r;
		wr(ADDR_CTRL, 8'h3C);
		fork
			hdsp_remote_i.send(9'h0FF, 832, 1'b0);
			begin
				repeat (600) @(posedge clk);
				wr(ADDR_DATA, 8'h81);
				hdsp_remote_i.recv(832, r);
				check({22'h0, r}, 32'h281);
			end
		join
		check(32'(rx_irq), 32'h0);
	endtask
	task automatic t_reserved();
		wr(ADDR_CTRL, 8'h1E);
		wr(ADDR_DATA, 8'h00);
		repeat (3000) @(posedge clk);
		check(32'(tx_irq), 32'h0);
		wr(ADDR_CTRL, 8'h1C);
		wait_irq(1'b1, 32'h1);
	endtask
	task automatic report_and_stop();
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 60000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_port();
		t_tx();
		t_rx();
		t_abort();
		t_reserved();
		report_and_stop();
	end
endmodule
